// ### rtl/dvsrc_pkg.sv
// Package: constants, config defaults and carrier types for the converter control block
package dvsrc_pkg;

	// Clocking and switching period
	localparam int SYS_CLK_HZ    = 20_000_000;                   // System clock rate
	localparam int FSW_HZ        = 3_250_000;                    // Internal switching rate
	localparam int SW_PERIOD_CYC = SYS_CLK_HZ / FSW_HZ;          // Period, rounded down to whole cycles
	localparam int MIN_ON_NS     = 100;                          // Least high-side on-time
	localparam int MIN_OFF_NS    = 100;                          // Least high-side off-time
	localparam int MIN_ON_CYC    = (MIN_ON_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int MIN_OFF_CYC   = (MIN_OFF_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

	// Sync clock dividers for 13, 19.2 and 26 MHz
	localparam logic [3:0] SYNC_DIV_13M  = 4'h4;
	localparam logic [3:0] SYNC_DIV_19M2 = 4'h6;
	localparam logic [3:0] SYNC_DIV_26M  = 4'h8;

	// Zero-crossing thresholds
	localparam logic [4:0] ZC_BIAS_HYST = 5'h10;                 // Above this: bias for hysteretic
	localparam logic [4:0] ZC_GO_HYST   = 5'h18;                 // Above this: hysteretic operation
	localparam logic [4:0] ZC_BIAS_PWM  = 5'h10;                 // Below this: bias for PWM
	localparam logic [4:0] ZC_GO_PWM    = 5'h08;                 // Below this: fixed frequency
	localparam logic [4:0] ZC_CNT_MAX   = 5'h1f;                 // Counter saturation

	// Voltage codes: 0.75 V + code x 10 mV
	localparam logic [5:0] VCODE_MIN  = 6'h00;                   // 0.75 V
	localparam logic [5:0] VCODE_1V27 = 6'h34;
	localparam logic [5:0] VCODE_1V05 = 6'h1e;
	localparam logic [5:0] VCODE_1V22 = 6'h2f;

	// Pulldown control field positions
	localparam int PD_EN_BIT  = 0;                               // Enable input pulldown
	localparam int PD_SELA_BIT = 1;                              // Select pin a pulldown
	localparam int PD_SELB_BIT = 2;                              // Select pin b pulldown

	// Sync clock rate choice
	typedef enum logic [1:0] {
		DVSRC_SYNC_13M  = 2'b00,
		DVSRC_SYNC_19M2 = 2'b01,
		DVSRC_SYNC_26M  = 2'b10
	} dvsrc_sync_rate_t;

	// One mode configuration slot
	typedef struct packed {
		logic [5:0] vcode;                                       // Output voltage code
		logic       pwr_save;                                    // 1 = power save, 0 = forced PWM
		logic       sync_en;                                     // External sync enable
	} dvsrc_slot_cfg_t;

	// Control word: pulldowns and ramp
	typedef struct packed {
		logic [2:0] pd_en;                                       // Pulldown enables, 1 = active
		logic       ramp_down;                                   // Active ramp-down in power save
		logic [2:0] ramp;                                        // Ramp-rate code
	} dvsrc_ctl_t;

	// Analog comparator results
	typedef struct packed {
		logic zero_cross;                                        // Inductor current below 50 mA
		logic out_low;                                           // Output below threshold
		logic out_high;                                          // Output above threshold + hysteresis
		logic cur_limit;                                         // Current above limit
		logic pwm_off;                                           // PWM loop ends on-time
		logic bias_ready;                                        // Requested bias has settled
	} dvsrc_sense_t;

	localparam dvsrc_slot_cfg_t SLOT0_RST = '{vcode: VCODE_1V27, pwr_save: 1'b0, sync_en: 1'b0};
	localparam dvsrc_slot_cfg_t SLOT1_RST = '{vcode: VCODE_1V05, pwr_save: 1'b1, sync_en: 1'b0};
	localparam dvsrc_slot_cfg_t SLOT2_RST = '{vcode: VCODE_1V22, pwr_save: 1'b0, sync_en: 1'b0};
	localparam dvsrc_slot_cfg_t SLOT3_RST = '{vcode: VCODE_1V05, pwr_save: 1'b0, sync_en: 1'b0};
	localparam dvsrc_ctl_t      CTL_RST   = '{pd_en: 3'h7, ramp_down: 1'b0, ramp: 3'h0};

endpackage : dvsrc_pkg

// ### rtl/dvsrc_top.sv
// Mode select, switch sequencing and output ramp control for a step-down converter
`timescale 1ns/1ps

module dvsrc_top (
	input  wire logic                     i_sys_clk,         // 20 MHz system clock
	input  wire logic                     i_rst_n,           // Async reset, active low
	input  wire logic                     i_en,              // Enable pin, asynchronous
	input  wire logic                     i_volt_sel_pin_a,  // Voltage select pin a, asynchronous
	input  wire logic                     i_volt_sel_pin_b,  // Voltage select pin b, asynchronous
	input  wire logic                     i_sync_clk,        // External sync clock pin, asynchronous
	input  wire logic                     i_uvlo,            // Supply undervoltage, asynchronous
	input  wire dvsrc_pkg::dvsrc_sense_t  i_sense,           // Analog comparators, asynchronous
	input  wire logic [1:0]               i_sync_rate,       // Sync clock rate choice
	input  wire logic                     i_slot_wr,         // Slot write strobe (data acknowledge)
	input  wire logic [1:0]               i_slot_sel,        // Slot to write
	input  wire dvsrc_pkg::dvsrc_slot_cfg_t i_slot_data,     // Slot write data
	input  wire logic                     i_ctl_wr,          // Control write strobe
	input  wire dvsrc_pkg::dvsrc_ctl_t    i_ctl_data,        // Control write data
	output logic                          o_hs_on,           // High-side switch drive
	output logic                          o_ls_on,           // Synchronous rectifier drive
	output logic [5:0]                    o_vout_code,       // Present DAC code
	output logic                          o_hyst_bias,       // Bias for hysteretic operation
	output logic                          o_hyst_mode,       // Hysteretic operation active
	output logic                          o_zc_det_en,       // Zero-cross comparator enable
	output logic                          o_soft_start,      // Soft-start in progress
	output logic [2:0]                    o_pd_en,           // Pulldown enables
	output logic [1:0]                    o_active_slot,     // Selected configuration slot
	output logic                          o_reg_on           // Regulator running
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: two flops before any logic

	typedef struct packed {
		logic                    en;
		logic                    sel_a;
		logic                    sel_b;
		logic                    sync;
		logic                    uvlo;
		dvsrc_pkg::dvsrc_sense_t sense;
	} dvsrc_pins_t;

	dvsrc_pins_t pins_meta_r;                                // First stage, read only by second
	dvsrc_pins_t pins_r;                                     // Second stage, safe to use
	dvsrc_pins_t pins_in;                                    // Raw pin bundle

	assign pins_in = '{en: i_en, sel_a: i_volt_sel_pin_a, sel_b: i_volt_sel_pin_b,
		sync: i_sync_clk, uvlo: i_uvlo, sense: i_sense};

	// Two-flop chain
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pins_meta_r <= '0;
			pins_r      <= '0;
		end else begin
			pins_meta_r <= pins_in;
			pins_r      <= pins_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Ramp step spacing in switching cycles, minus one
	function automatic logic [7:0] ramp_limit(input logic [2:0] code);
		ramp_limit = (8'h01 << code) - 8'h01;
	endfunction : ramp_limit

	// Sync divider for the chosen rate
	function automatic logic [3:0] sync_div(input logic [1:0] rate);
		case (dvsrc_pkg::dvsrc_sync_rate_t'(rate))
			dvsrc_pkg::DVSRC_SYNC_13M:  sync_div = dvsrc_pkg::SYNC_DIV_13M;
			dvsrc_pkg::DVSRC_SYNC_19M2: sync_div = dvsrc_pkg::SYNC_DIV_19M2;
			default:                    sync_div = dvsrc_pkg::SYNC_DIV_26M;
		endcase
	endfunction : sync_div

	////////////////////////////////////////////////////////////////////////////
	// Configuration slots and control word

	dvsrc_pkg::dvsrc_slot_cfg_t slot_r   [4];                // Four mode configurations
	dvsrc_pkg::dvsrc_slot_cfg_t slot_nxt [4];
	dvsrc_pkg::dvsrc_ctl_t      ctl_r;                       // Pulldown and ramp control
	dvsrc_pkg::dvsrc_ctl_t      ctl_nxt;
	logic [1:0]                 sel;                         // Active slot from pins
	dvsrc_pkg::dvsrc_slot_cfg_t act;                         // Active configuration

	assign sel = {pins_r.sel_a, pins_r.sel_b};
	assign act = slot_r[sel];                                // Writes show next cycle

	// Writes, lockout and enable-low defaults
	always_comb begin
		slot_nxt = slot_r;
		ctl_nxt  = ctl_r;
		if (pins_r.uvlo) begin
			slot_nxt[0] = dvsrc_pkg::SLOT0_RST;
			slot_nxt[1] = dvsrc_pkg::SLOT1_RST;
			slot_nxt[2] = dvsrc_pkg::SLOT2_RST;
			slot_nxt[3] = dvsrc_pkg::SLOT3_RST;
			ctl_nxt     = dvsrc_pkg::CTL_RST;
		end else begin
			if (i_slot_wr) begin                             // Outside lockout only, active or not
				slot_nxt[i_slot_sel] = i_slot_data;
			end
			if (i_ctl_wr) begin
				ctl_nxt.ramp      = i_ctl_data.ramp;
				ctl_nxt.ramp_down = i_ctl_data.ramp_down;
				if (pins_r.en) begin                         // Pulldowns only after enable
					ctl_nxt.pd_en = i_ctl_data.pd_en;
				end
			end
			if (!pins_r.en) begin                            // Enable low restores pulldowns
				ctl_nxt.pd_en = dvsrc_pkg::CTL_RST.pd_en;
			end
		end
	end

	// Register the slots
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slot_r[0] <= dvsrc_pkg::SLOT0_RST;
			slot_r[1] <= dvsrc_pkg::SLOT1_RST;
			slot_r[2] <= dvsrc_pkg::SLOT2_RST;
			slot_r[3] <= dvsrc_pkg::SLOT3_RST;
			ctl_r     <= dvsrc_pkg::CTL_RST;
		end else begin
			slot_r <= slot_nxt;
			ctl_r  <= ctl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Switching clock: internal divider or divided sync clock

	logic [3:0] int_cnt_r, int_cnt_nxt;                      // Internal period counter
	logic [3:0] syn_cnt_r, syn_cnt_nxt;                      // Sync edge counter
	logic       sync_d_r;                                    // Previous synced sync level
	logic       tick;                                        // Start of switching cycle

	// Pick the tick source; sync edges are seen only on the second flop
	always_comb begin
		int_cnt_nxt = int_cnt_r + 4'h1;
		syn_cnt_nxt = syn_cnt_r;
		tick        = 1'b0;
		if (int_cnt_r == 4'(dvsrc_pkg::SW_PERIOD_CYC - 1)) begin
			int_cnt_nxt = 4'h0;
			tick        = !act.sync_en;
		end
		if (pins_r.sync && !sync_d_r) begin
			if (syn_cnt_r >= sync_div(i_sync_rate) - 4'h1) begin
				syn_cnt_nxt = 4'h0;
				tick        = act.sync_en;
			end else begin
				syn_cnt_nxt = syn_cnt_r + 4'h1;
			end
		end
	end

	// Register the dividers
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_cnt_r <= 4'h0;
			syn_cnt_r <= 4'h0;
			sync_d_r  <= 1'b0;
		end else begin
			int_cnt_r <= int_cnt_nxt;
			syn_cnt_r <= syn_cnt_nxt;
			sync_d_r  <= pins_r.sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Ramp and soft-start

	logic [5:0] code_r, code_nxt;                            // Present DAC code
	logic [7:0] rcnt_r, rcnt_nxt;                            // Cycles since last step
	logic       soft_r, soft_nxt;                            // Soft-start active
	logic       en_d_r;                                      // Previous enable
	logic       ramp_dn;                                     // Descending toward target
	logic       zc_en;                                       // Zero-cross comparator enable

	assign ramp_dn = pins_r.en && (code_r > act.vcode);
	// Only power save with active ramp-down blanks the comparator
	assign zc_en   = !(act.pwr_save && ctl_r.ramp_down && ramp_dn);

	// Step the code toward the target; mode change simply retargets
	always_comb begin
		code_nxt = code_r;
		rcnt_nxt = rcnt_r;
		soft_nxt = soft_r;
		if (!pins_r.en) begin                                // Shut down
			code_nxt = dvsrc_pkg::VCODE_MIN;
			rcnt_nxt = 8'h00;
			soft_nxt = 1'b0;
		end else if (!en_d_r) begin                          // Always from bottom
			code_nxt = dvsrc_pkg::VCODE_MIN;
			rcnt_nxt = 8'h00;
			soft_nxt = 1'b1;
		end else if (ramp_dn && act.pwr_save && !ctl_r.ramp_down) begin
			code_nxt = act.vcode;                            // Load discharges output
			rcnt_nxt = 8'h00;
		end else if (code_r != act.vcode) begin
			if (tick) begin
				if (rcnt_r >= ramp_limit(ctl_r.ramp)) begin
					rcnt_nxt = 8'h00;
					code_nxt = ramp_dn ? code_r - 6'h01 : code_r + 6'h01;
				end else begin
					rcnt_nxt = rcnt_r + 8'h01;
				end
			end
		end else begin
			soft_nxt = 1'b0;                                 // Target reached ends soft-start
			rcnt_nxt = 8'h00;
		end
	end

	// Register the ramp
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			code_r <= dvsrc_pkg::VCODE_MIN;
			rcnt_r <= 8'h00;
			soft_r <= 1'b0;
			en_d_r <= 1'b0;
		end else begin
			code_r <= code_nxt;
			rcnt_r <= rcnt_nxt;
			soft_r <= soft_nxt;
			en_d_r <= pins_r.en;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Zero-crossing count and power-save operating state

	typedef enum logic [1:0] {
		PS_PWM       = 2'b00,                                // Fixed frequency
		PS_BIAS_HYST = 2'b01,                                // Biasing for hysteretic
		PS_HYST      = 2'b10,                                // Hysteretic operation
		PS_BIAS_PWM  = 2'b11                                 // Biasing back for PWM
	} dvsrc_ps_t;

	dvsrc_ps_t  ps_r, ps_nxt;                                // Operating state
	logic [4:0] zc_cnt_r, zc_cnt_nxt;                        // Consecutive zero-crossing cycles
	logic       zc_seen_r, zc_seen_nxt;                      // Crossing seen this cycle
	logic       zc_now;                                      // Crossing now

	assign zc_now = pins_r.sense.zero_cross && o_ls_on && zc_en;

	// Count per cycle; a crossing at the tick still counts
	always_comb begin
		zc_cnt_nxt  = zc_cnt_r;
		zc_seen_nxt = zc_seen_r || zc_now;
		if (tick) begin
			zc_seen_nxt = 1'b0;
			if (zc_seen_r || zc_now) begin
				zc_cnt_nxt = (zc_cnt_r == dvsrc_pkg::ZC_CNT_MAX) ? zc_cnt_r : zc_cnt_r + 5'h01;
			end else begin
				zc_cnt_nxt = 5'h00;
			end
		end
		ps_nxt = ps_r;
		if (!pins_r.en || !act.pwr_save) begin               // Forced PWM never leaves fixed frequency
			ps_nxt = PS_PWM;
		end else begin
			case (ps_r)
				PS_PWM: begin
					if (zc_cnt_r > dvsrc_pkg::ZC_BIAS_HYST) ps_nxt = PS_BIAS_HYST;
				end
				PS_BIAS_HYST: begin
					if (pins_r.sense.bias_ready && zc_cnt_r > dvsrc_pkg::ZC_GO_HYST) begin
						ps_nxt = PS_HYST;
					end else if (zc_cnt_r < dvsrc_pkg::ZC_BIAS_PWM) begin
						ps_nxt = PS_PWM;                     // Load came back before switching
					end
				end
				PS_HYST: begin
					if (zc_cnt_r < dvsrc_pkg::ZC_BIAS_PWM) ps_nxt = PS_BIAS_PWM;
				end
				PS_BIAS_PWM: begin
					if (pins_r.sense.bias_ready && zc_cnt_r < dvsrc_pkg::ZC_GO_PWM) begin
						ps_nxt = PS_PWM;
					end
				end
				default: ps_nxt = PS_PWM;
			endcase
		end
	end

	// Register the counter and state
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ps_r      <= PS_PWM;
			zc_cnt_r  <= 5'h00;
			zc_seen_r <= 1'b0;
		end else begin
			ps_r      <= ps_nxt;
			zc_cnt_r  <= zc_cnt_nxt;
			zc_seen_r <= zc_seen_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Switch sequencing

	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,                                     // Both off, waiting
		SW_HS   = 2'b01,                                     // High side on
		SW_LS   = 2'b10,                                     // Rectifier on
		SW_OFF  = 2'b11                                      // Both off after zero crossing
	} dvsrc_sw_t;

	dvsrc_sw_t  sw_r, sw_nxt;                                // Switch state
	logic [3:0] tmr_r, tmr_nxt;                              // Cycles in present state
	logic       hyst;                                        // Hysteretic control active
	logic       on_ok, off_ok;                               // Min on / off elapsed
	logic       start_hs;                                    // Begin a high-side pulse

	assign hyst     = (ps_r == PS_HYST);
	assign on_ok    = (tmr_r >= 4'(dvsrc_pkg::MIN_ON_CYC - 1));
	assign off_ok   = (tmr_r >= 4'(dvsrc_pkg::MIN_OFF_CYC - 1));
	// Hysteretic starts on low output; PWM starts each cycle
	assign start_hs = hyst ? (off_ok && pins_r.sense.out_low) : tick;

	// Next switch state; the two switches are never on together
	always_comb begin
		sw_nxt  = sw_r;
		tmr_nxt = (tmr_r == 4'hf) ? tmr_r : tmr_r + 4'h1;
		case (sw_r)
			SW_IDLE, SW_OFF: begin
				if (start_hs) sw_nxt = SW_HS;
			end
			SW_HS: begin
				if (hyst) begin
					if (on_ok && (pins_r.sense.out_high || pins_r.sense.cur_limit)) sw_nxt = SW_LS;
				end else if (on_ok && (pins_r.sense.pwm_off || pins_r.sense.cur_limit)) begin
					sw_nxt = SW_LS;                          // Off-time begins
				end
			end
			SW_LS: begin
				if (start_hs) begin
					sw_nxt = SW_HS;                          // Cycle end or next pulse
				end else if (act.pwr_save && zc_now) begin
					sw_nxt = SW_OFF;                         // Current near zero
				end
			end
			default: sw_nxt = SW_IDLE;
		endcase
		if (!pins_r.en) sw_nxt = SW_IDLE;
		if (sw_nxt != sw_r) tmr_nxt = 4'h0;
	end

	// Register the switch state
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sw_r  <= SW_IDLE;
			tmr_r <= 4'h0;
		end else begin
			sw_r  <= sw_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output flops

	// Outputs come from flops; drives follow the switch state next
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hs_on       <= 1'b0;
			o_ls_on       <= 1'b0;
			o_vout_code   <= dvsrc_pkg::VCODE_MIN;
			o_hyst_bias   <= 1'b0;
			o_hyst_mode   <= 1'b0;
			o_zc_det_en   <= 1'b1;
			o_soft_start  <= 1'b0;
			o_pd_en       <= dvsrc_pkg::CTL_RST.pd_en;
			o_active_slot <= 2'h0;
			o_reg_on      <= 1'b0;
		end else begin
			o_hs_on       <= (sw_nxt == SW_HS);
			o_ls_on       <= (sw_nxt == SW_LS);
			o_vout_code   <= code_nxt;
			o_hyst_bias   <= (ps_nxt == PS_BIAS_HYST) || (ps_nxt == PS_HYST);
			o_hyst_mode   <= (ps_nxt == PS_HYST);
			o_zc_det_en   <= zc_en;
			o_soft_start  <= soft_nxt;
			o_pd_en       <= ctl_nxt.pd_en;
			o_active_slot <= sel;
			o_reg_on      <= pins_r.en;
		end
	end

endmodule : dvsrc_top

// ### test/dvsrc_checker.sv
// Checker: port-level properties of the converter control block
`timescale 1ns/1ps
module dvsrc_checker (
	input wire logic                  i_sys_clk,        // Clock
	input wire logic                  i_rst_n,          // Reset, low
	input wire logic                  i_volt_sel_pin_a, // Pin a
	input wire logic                  i_volt_sel_pin_b, // Pin b
	input wire logic                  i_ctl_wr,         // Strobe
	input wire dvsrc_pkg::dvsrc_ctl_t i_ctl_data,       // Control
	input wire logic                  o_hs_on,          // High side
	input wire logic                  o_ls_on,          // Rectifier
	input wire logic [5:0]            o_vout_code,      // Code
	input wire logic                  o_hyst_bias,      // Bias
	input wire logic                  o_hyst_mode,      // Hysteretic
	input wire logic                  o_soft_start,     // Soft-start
	input wire logic [2:0]            o_pd_en,          // Pulldowns
	input wire logic [1:0]            o_active_slot,    // Slot
	input wire logic                  o_reg_on          // Running
);
	// One clock domain, so one default for all checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////
	// One upward step of the code
	sequence s_up;
		o_vout_code == $past(o_vout_code) + 6'h01;
	endsequence
	property p_excl; !(o_hs_on && o_ls_on); endproperty
	a_excl: assert property (p_excl) else $error("switch overlap");
	property p_slot; $stable({i_volt_sel_pin_a, i_volt_sel_pin_b})[*4] |-> o_active_slot == {i_volt_sel_pin_a, i_volt_sel_pin_b}; endproperty
	a_slot: assert property (p_slot) else $error("slot select");
	property p_pd; !o_reg_on |-> o_pd_en == 3'h7; endproperty
	a_pd: assert property (p_pd) else $error("pulldowns off while disabled");
	// Running on both sides of the write, so the synced enable took it
	property p_pdw; i_ctl_wr && o_reg_on ##1 o_reg_on |-> o_pd_en == $past(i_ctl_data.pd_en); endproperty
	a_pdw: assert property (p_pdw) else $error("pulldown write lost");
	property p_ss; $rose(o_reg_on) |-> o_soft_start && o_vout_code == 6'h00; endproperty
	a_ss: assert property (p_ss) else $error("soft-start start");
	property p_off; !o_reg_on && !$past(o_reg_on) |-> !o_hs_on && !o_ls_on; endproperty
	a_off: assert property (p_off) else $error("switching while off");
	property p_hyst; $rose(o_hyst_mode) |-> $past(o_hyst_bias); endproperty
	a_hyst: assert property (p_hyst) else $error("hysteretic unbiased");
	property p_hmin; $rose(o_hs_on) && o_reg_on |=> o_hs_on || !o_reg_on; endproperty
	a_hmin: assert property (p_hmin) else $error("on-time short");
	// Upward steps are a switching period apart at least
	property p_ramp; s_up |=> $stable(o_vout_code)[*5]; endproperty
	a_ramp: assert property (p_ramp) else $error("steps too close");
endmodule : dvsrc_checker
bind dvsrc_top dvsrc_checker i_dvsrc_checker (.*);

// ### test/dvsrc_host.sv
// Host model driving the enable and voltage-select pins
`timescale 1ns/1ps
module dvsrc_host (
	input wire logic       i_sys_clk, // Clock
	input wire logic       i_run,     // Wanted run state
	input wire logic [1:0] i_slot,    // Wanted slot
	output logic           o_en,      // Enable pin
	output logic           o_sel_a,   // Select pin a
	output logic           o_sel_b    // Select pin b
);
	// Pulled-down pins start low
	initial {o_en, o_sel_a, o_sel_b} = 3'h0;
	// Pins move after the edge, never on it
	always @(posedge i_sys_clk) begin
		o_en <= #1 i_run;
		{o_sel_a, o_sel_b} <= #1 i_slot;
	end
endmodule : dvsrc_host

// ### test/dvsrc_top_tb.sv
// Testbench: slot, pulldown, ramp, lockout and power-save scenarios
`timescale 1ns/1ps
module dvsrc_top_tb;
	logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, uvlo = 1'b0, sw = 1'b0, cw = 1'b0, syc = 1'b0; // Drives
	logic en, pa, pb, hs, ls, hb, hm, ss, rg, zd;    // Pins, status
	logic [1:0] slot = 2'h0, sl = 2'h0, as;          // Slots
	logic [5:0] vc;                                  // Code
	logic [2:0] pd;                                  // Pulldowns
	dvsrc_pkg::dvsrc_slot_cfg_t sd = 8'h00;          // Slot data
	dvsrc_pkg::dvsrc_ctl_t      cd = 7'h00;          // Control data
	dvsrc_pkg::dvsrc_sense_t    sn = 6'h00;          // Comparators
	int n_mismatch = 0, cmp_count = 0, k, tmo = 0;   // Counters
	always #25 clk = ~clk;
	always #100 syc = ~syc;                          // Sync clock: a rising edge every 4 clocks
	dvsrc_host i_dvsrc_host (.i_sys_clk(clk), .i_run(run), .i_slot(slot), .o_en(en), .o_sel_a(pa), .o_sel_b(pb));
	// Sync pin runs slow so the system clock sees every edge
	dvsrc_top i_dvsrc_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_en(en), .i_volt_sel_pin_a(pa),
		.i_volt_sel_pin_b(pb), .i_sync_clk(syc), .i_uvlo(uvlo), .i_sense(sn), .i_sync_rate(2'h0),
		.i_slot_wr(sw), .i_slot_sel(sl), .i_slot_data(sd), .i_ctl_wr(cw), .i_ctl_data(cd), .o_hs_on(hs),
		.o_ls_on(ls), .o_vout_code(vc), .o_hyst_bias(hb), .o_hyst_mode(hm), .o_zc_det_en(zd),
		.o_soft_start(ss), .o_pd_en(pd), .o_active_slot(as), .o_reg_on(rg));
	////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [1:0] s, input logic [7:0] d);
		sl = s;
		sd = d;
		sw = 1'b1;
		cyc(1);
		sw = 1'b0;
	endtask : wr
	task ctl(input logic [6:0] d);
		cd = d;
		cw = 1'b1;
		cyc(1);
		cw = 1'b0;
		cyc(1);
	endtask : ctl
	// Write slot 0 and count cycles until the code lands
	task rmp(input logic [7:0] d);
		wr(2'h0, d);
		for (k = 0; k < 99 && vc !== d[7:2]; k++) cyc(1);
		chk(8'(k > 20 && k < 40), 8'h01);
	endtask : rmp
	task start(input logic [1:0] s);
		slot = s;
		run = 1'b1;
		cyc(5);
		for (k = 0; k < 900 && ss !== 1'b0; k++) cyc(1);
		cyc(6);
	endtask : start
	task automatic t_slots();
		logic [5:0] dv [4] = '{6'h34, 6'h1e, 6'h2f, 6'h1e};
		for (int s = 0; s < 4; s++) begin
			start(2'(s));
			chk(vc, dv[s]);
			chk(as, 8'(s));
			run = 1'b0;
			cyc(8);
			chk({hs, ls, vc}, 8'h00);
		end
	endtask : t_slots
	task t_pd();
		start(2'h0);
		ctl(7'h00);
		chk(pd, 8'h00);
		ctl(7'h60);
		chk(pd, 8'h06);
		run = 1'b0;
		cyc(8);
		chk(pd, 8'h07);
		ctl(7'h00);
		chk(pd, 8'h07);
	endtask : t_pd
	task t_ramp();
		start(2'h0);
		ctl(7'h01);
		rmp(8'hdc);
		rmp(8'hd0);
		uvlo = 1'b1;
		cyc(4);
		wr(2'h0, 8'h20);
		uvlo = 1'b0;
		cyc(40);
		chk({pd, vc[4:0]}, 8'hf4);
	endtask : t_ramp
	// Slot 0 on the sync clock: three steps, one per 16 clocks
	task t_sync();
		wr(2'h0, 8'hdd);
		for (k = 0; k < 99 && vc !== 6'h37; k++) cyc(1);
		chk(8'(k > 32 && k < 49), 8'h01);
	endtask : t_sync
	// Crossings on every cycle, then none
	task t_hyst();
		slot = 2'h1;
		sn = 6'h23;
		for (k = 0; k < 900 && hm !== 1'b1; k++) cyc(1);
		chk({hb, hm}, 8'h03);
		sn = 6'h03;
		for (k = 0; k < 900 && hm !== 1'b0; k++) cyc(1);
		chk(hm, 8'h00);
		ctl(7'h08);
		wr(2'h1, 8'h52);
		cyc(1);
		chk(zd, 8'h00);
		cyc(70);
		chk({zd, vc}, 8'h54);
	endtask : t_hyst
	task end_of_test();
		if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	// Hang guard
	always @(posedge clk) begin
		tmo++;
		if (tmo == 12000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	initial begin
		cyc(6);
		rst_n = 1'b1;
		cyc(2);
		chk({rg, pd}, 8'h07);
		t_slots();
		t_pd();
		t_ramp();
		t_sync();
		t_hyst();
		end_of_test();
	end
endmodule : dvsrc_top_tb
